// File: hdl/seesap_pkg.sv
package seesap_pkg;

  // Array shape: 256 pages of 32 bytes
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_COUNT = 256;
  localparam int MEM_BYTES = PAGE_BYTES * PAGE_COUNT;
  localparam int ADDR_W = 13;
  localparam int PAGE_IDX_W = 5;
  localparam int PAGE_NUM_W = 8;

  // Byte plus four check bits of a single-error-correcting code
  localparam int DATA_W = 8;
  localparam int CODE_W = 12;

  // Select code fields
  localparam logic [3:0] TYPE_MEM = 4'hA;
  localparam logic [3:0] TYPE_ID = 4'hB;
  localparam int SEL_TYPE_MSB = 7;
  localparam int SEL_TYPE_LSB = 4;
  localparam int SEL_STRAP_MSB = 3;
  localparam int SEL_STRAP_LSB = 1;
  localparam int SEL_RW_BIT = 0;

  // Upper address byte: bit 10 of the address picks the lock command
  localparam int ADDR_HI_LOCK_BIT = 2;
  localparam int ADDR_HI_MSB = 4;

  // Bit counter reaches this after the eighth bit of a byte
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;

  // Serial clock up to 1 MHz; half period is 50 system clocks at 100 MHz
  localparam int CLK_SYS_HZ = 100_000_000;
  localparam int SCL_MAX_HZ = 1_000_000;

  localparam int SYNC_STAGES = 2;
  localparam int PIN_COUNT = 6;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEL,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_WDATA,
    ST_RDATA,
    ST_WAIT
  } seesap_state_t;

endpackage

// File: hdl/seesap_sync.sv
`timescale 1ns/1ns
module seesap_sync
  import seesap_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = meta_q;
    sync_d = sync_q;
    if (clk_en) begin
      meta_d = pin_in;
      sync_d = meta_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign pin_sync = sync_q;

endmodule

// File: hdl/seesap_ecc.sv
`timescale 1ns/1ns
module seesap_ecc
  import seesap_pkg::*;
(
  input wire logic [DATA_W-1:0] wr_data,
  output logic [CODE_W-1:0] wr_code,
  input wire logic [CODE_W-1:0] rd_code,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_fixed
);

  // Check bits sit at the power-of-two positions, counted from one
  function automatic logic [CODE_W-1:0] encode(input logic [DATA_W-1:0] d);
    logic [CODE_W-1:0] c;
    int k;
    c = '0;
    k = 0;
    for (int p = 1; p <= CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p-1] = d[k];
        k++;
      end
    end
    for (int i = 1; i <= DATA_W; i = i * 2) begin
      for (int p = 1; p <= CODE_W; p++) begin
        if (((p & i) != 0) && (p != i)) begin
          c[i-1] = c[i-1] ^ c[p-1];
        end
      end
    end
    return c;
  endfunction

  always_comb begin
    logic [3:0] syn;
    logic [CODE_W-1:0] c;
    int k;
    syn = '0;
    c = rd_code;
    k = 0;
    rd_data = '0;
    for (int p = 1; p <= CODE_W; p++) begin
      if (rd_code[p-1]) begin
        syn = syn ^ 4'(p);
      end
    end
    for (int p = 1; p <= CODE_W; p++) begin
      if (syn == 4'(p)) begin
        c[p-1] = ~c[p-1];
      end
    end
    for (int p = 1; p <= CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        rd_data[k] = c[p-1];
        k++;
      end
    end
    rd_fixed = (syn != 4'h0);
  end

  assign wr_code = encode(wr_data);

endmodule

// File: hdl/seesap_top.sv
`timescale 1ns/1ns
module seesap_top
  import seesap_pkg::*;
#(
  parameter int WRITE_CYCLES = 64
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic strap_select_bit2,
  input wire logic strap_select_bit1,
  input wire logic strap_select_bit0,
  input wire logic write_protect_input,
  output logic write_busy,
  output logic id_page_locked,
  output logic ecc_corrected
);

  // Must outlast the one-byte-per-clock commit of a full page
  localparam logic [15:0] BUSY_LEN = 16'(WRITE_CYCLES);

  logic [PIN_COUNT-1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic [2:0] strap_s;
  logic wp_s;

  seesap_sync #(
    .WIDTH(PIN_COUNT)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pin_in({scl_in, sda_in, strap_select_bit2, strap_select_bit1,
             strap_select_bit0, write_protect_input}),
    .pin_sync(pins_s)
  );

  assign scl_s = pins_s[5];
  assign sda_s = pins_s[4];
  assign strap_s = pins_s[3:1];
  assign wp_s = pins_s[0];

  seesap_state_t state_q, state_d;
  logic scl_p_q, scl_p_d;
  logic sda_p_q, sda_p_d;
  logic [3:0] cnt_q, cnt_d;
  logic in_ack_q, in_ack_d;
  logic ack_q, ack_d;
  logic oe_q, oe_d;
  logic [7:0] rx_q, rx_d;
  logic [7:0] tx_q, tx_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic sel_id_q, sel_id_d;
  logic rw_q, rw_d;
  logic lock_sel_q, lock_sel_d;
  logic lock_req_q, lock_req_d;
  logic locked_q, locked_d;
  logic [7:0] buf_q [PAGE_BYTES];
  logic [7:0] buf_d [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mask_q, mask_d;
  logic [PAGE_NUM_W-1:0] wr_page_q, wr_page_d;
  logic wr_id_q, wr_id_d;
  logic [15:0] busy_q, busy_d;
  logic [5:0] commit_q, commit_d;
  logic fixed_q, fixed_d;

  logic [CODE_W-1:0] mem_q [MEM_BYTES];
  logic [7:0] id_q [PAGE_BYTES];
  logic mem_we;
  logic id_we;
  logic [ADDR_W-1:0] mem_waddr;
  logic [PAGE_IDX_W-1:0] widx;
  logic [CODE_W-1:0] wr_code;
  logic [CODE_W-1:0] rd_code;
  logic [7:0] mem_byte;
  logic rd_fixed;
  logic [7:0] rd_byte;

  assign widx = commit_q[PAGE_IDX_W-1:0];
  assign mem_waddr = {wr_page_q, widx};
  assign rd_code = mem_q[addr_q];

  seesap_ecc u_ecc (
    .wr_data(buf_q[widx]),
    .wr_code(wr_code),
    .rd_code(rd_code),
    .rd_data(mem_byte),
    .rd_fixed(rd_fixed)
  );

  always_comb begin
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    logic [7:0] byte_in;
    logic match;
    rise = scl_s & ~scl_p_q;
    fall = ~scl_s & scl_p_q;
    // Edge of data while clock high marks start or stop
    start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
    stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
    byte_in = {rx_q[6:0], sda_s};
    match = 1'b0;
    rd_byte = sel_id_q ? id_q[addr_q[PAGE_IDX_W-1:0]] : mem_byte;
    state_d = state_q;
    scl_p_d = scl_s;
    sda_p_d = sda_s;
    cnt_d = cnt_q;
    in_ack_d = in_ack_q;
    ack_d = ack_q;
    oe_d = oe_q;
    rx_d = rx_q;
    tx_d = tx_q;
    addr_d = addr_q;
    sel_id_d = sel_id_q;
    rw_d = rw_q;
    lock_sel_d = lock_sel_q;
    lock_req_d = lock_req_q;
    locked_d = locked_q;
    buf_d = buf_q;
    mask_d = mask_q;
    wr_page_d = wr_page_q;
    wr_id_d = wr_id_q;
    busy_d = busy_q;
    commit_d = commit_q;
    fixed_d = fixed_q;
    mem_we = 1'b0;
    id_we = 1'b0;
    if (busy_q != 16'h0000) begin
      // Bus is deaf while the page is committed, one byte per clock
      busy_d = busy_q - 16'h0001;
      state_d = ST_IDLE;
      oe_d = 1'b0;
      if (!commit_q[5]) begin
        commit_d = commit_q + 6'h01;
        if (mask_q[widx]) begin
          if (wr_id_q) begin
            id_we = 1'b1;
          end else begin
            mem_we = 1'b1;
          end
        end
      end
      if (busy_q == 16'h0001) begin
        mask_d = '0;
        if (lock_req_q) begin
          locked_d = 1'b1;
        end
        lock_req_d = 1'b0;
      end
    end else if (start_c) begin
      state_d = ST_SEL;
      cnt_d = 4'h0;
      in_ack_d = 1'b0;
      oe_d = 1'b0;
      mask_d = '0;
      lock_req_d = 1'b0;
    end else if (stop_c) begin
      if (state_q == ST_WDATA && (mask_q != '0 || lock_req_q)) begin
        busy_d = BUSY_LEN;
        commit_d = 6'h00;
      end
      state_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (state_q != ST_IDLE && state_q != ST_WAIT) begin
      if (rise) begin
        if (!in_ack_q && cnt_q < BITS_PER_BYTE) begin
          rx_d = byte_in;
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == LAST_DATA_BIT) begin
            unique case (state_q)
              ST_SEL: begin
                match = (byte_in[SEL_TYPE_MSB:SEL_TYPE_LSB] == TYPE_MEM ||
                  byte_in[SEL_TYPE_MSB:SEL_TYPE_LSB] == TYPE_ID) &&
                  (byte_in[SEL_STRAP_MSB:SEL_STRAP_LSB] == strap_s);
                ack_d = match;
                if (!match) begin
                  state_d = ST_WAIT;
                end
                sel_id_d = (byte_in[SEL_TYPE_MSB:SEL_TYPE_LSB] == TYPE_ID);
                rw_d = byte_in[SEL_RW_BIT];
              end
              ST_ADDR_HI: begin
                addr_d[ADDR_W-1:8] = byte_in[ADDR_HI_MSB:0];
                lock_sel_d = byte_in[ADDR_HI_LOCK_BIT];
                ack_d = 1'b1;
              end
              ST_ADDR_LO: begin
                addr_d[7:0] = byte_in;
                ack_d = 1'b1;
              end
              ST_WDATA: begin
                if (wp_s || (sel_id_q && locked_q)) begin
                  ack_d = 1'b0;
                end else if (sel_id_q && lock_sel_q) begin
                  lock_req_d = 1'b1;
                  ack_d = 1'b1;
                end else begin
                  buf_d[addr_q[PAGE_IDX_W-1:0]] = byte_in;
                  mask_d[addr_q[PAGE_IDX_W-1:0]] = 1'b1;
                  wr_page_d = addr_q[ADDR_W-1:PAGE_IDX_W];
                  wr_id_d = sel_id_q;
                  // Page write wraps inside its own page
                  addr_d[PAGE_IDX_W-1:0] =
                    addr_q[PAGE_IDX_W-1:0] + 5'h01;
                  ack_d = 1'b1;
                end
              end
              ST_RDATA: begin
                ack_d = 1'b0;
                if (sel_id_q) begin
                  addr_d[PAGE_IDX_W-1:0] =
                    addr_q[PAGE_IDX_W-1:0] + 5'h01;
                end else begin
                  addr_d = addr_q + 13'h0001;
                end
              end
              default: begin
                ack_d = 1'b0;
              end
            endcase
          end
        end else if (in_ack_q && state_q == ST_RDATA && sda_s) begin
          // Master declined the byte: read ends
          state_d = ST_WAIT;
          in_ack_d = 1'b0;
          oe_d = 1'b0;
        end
      end else if (fall) begin
        if (cnt_q == BITS_PER_BYTE && !in_ack_q) begin
          in_ack_d = 1'b1;
          oe_d = ack_q;
        end else if (in_ack_q) begin
          in_ack_d = 1'b0;
          cnt_d = 4'h0;
          oe_d = 1'b0;
          unique case (state_q)
            ST_SEL: state_d = rw_q ? ST_RDATA : ST_ADDR_HI;
            ST_ADDR_HI: state_d = ST_ADDR_LO;
            ST_ADDR_LO: state_d = ST_WDATA;
            default: state_d = state_q;
          endcase
          if ((state_q == ST_SEL && rw_q) || state_q == ST_RDATA) begin
            tx_d = rd_byte;
            oe_d = ~rd_byte[7];
            fixed_d = rd_fixed & ~sel_id_q;
          end
        end else if (state_q == ST_RDATA && cnt_q != 4'h0) begin
          tx_d = {tx_q[6:0], 1'b0};
          oe_d = ~tx_q[6];
        end
      end
    end else begin
      oe_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      scl_p_q <= 1'b0;
      sda_p_q <= 1'b0;
      cnt_q <= 4'h0;
      in_ack_q <= 1'b0;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      addr_q <= '0;
      sel_id_q <= 1'b0;
      rw_q <= 1'b0;
      lock_sel_q <= 1'b0;
      lock_req_q <= 1'b0;
      locked_q <= 1'b0;
      mask_q <= '0;
      wr_page_q <= '0;
      wr_id_q <= 1'b0;
      busy_q <= 16'h0000;
      commit_q <= 6'h00;
      fixed_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      scl_p_q <= scl_p_d;
      sda_p_q <= sda_p_d;
      cnt_q <= cnt_d;
      in_ack_q <= in_ack_d;
      ack_q <= ack_d;
      oe_q <= oe_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      addr_q <= addr_d;
      sel_id_q <= sel_id_d;
      rw_q <= rw_d;
      lock_sel_q <= lock_sel_d;
      lock_req_q <= lock_req_d;
      locked_q <= locked_d;
      mask_q <= mask_d;
      wr_page_q <= wr_page_d;
      wr_id_q <= wr_id_d;
      busy_q <= busy_d;
      commit_q <= commit_d;
      fixed_q <= fixed_d;
    end
  end

  // Storage has no reset: it models nonvolatile contents
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      buf_q <= buf_d;
      if (mem_we) begin
        mem_q[mem_waddr] <= wr_code;
      end
      if (id_we) begin
        id_q[widx] <= buf_q[widx];
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = oe_q;
  assign write_busy = (busy_q != 16'h0000);
  assign id_page_locked = locked_q;
  assign ecc_corrected = fixed_q;

endmodule

// File: tb/seesap_mst_model.sv
`timescale 1ns/1ns
module seesap_mst_model (
  input wire logic clk_sys,
  input wire logic sda_wire,
  output logic scl,
  output logic pull
);
  // Low phase lasts this many system clocks plus four; raise it for a slow master
  int low_len = 4;

  initial begin
    scl = 1'h1;
    pull = 1'h0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    wt(low_len);
    pull <= ~b;
    wt(4);
    scl <= 1'h1;
    wt(4);
    r = sda_wire;
    wt(4);
    scl <= 1'h0;
  endtask

  task automatic start();
    wt(4);
    pull <= 1'h0;
    wt(4);
    scl <= 1'h1;
    wt(8);
    pull <= 1'h1;
    wt(8);
    scl <= 1'h0;
  endtask

  // Stop closes a write and launches the program cycle
  task automatic stop();
    wt(4);
    pull <= 1'h1;
    wt(4);
    scl <= 1'h1;
    wt(8);
    pull <= 1'h0;
    wt(8);
  endtask

  // Line released after eight bits unless acking a read
  task automatic xfer(input logic [7:0] d, input logic nine,
                      output logic [7:0] r, output logic nine_seen);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(nine, nine_seen);
  endtask
endmodule

// File: tb/seesap_top_assertions.sv
`timescale 1ns/1ns
module seesap_top_checker
  import seesap_pkg::*;
#(
  parameter int WRITE_CYCLES = 64
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_protect_input,
  input wire logic write_busy,
  input wire logic id_page_locked
);
  logic scl_q, sda_q;
  logic [3:0] since_stop_q, since_stop_d;
  int busy_len_q, busy_len_d;

  always_comb begin
    since_stop_d = (since_stop_q == 4'hF) ? since_stop_q : since_stop_q + 4'h1;
    if (scl_in && scl_q && sda_in && !sda_q) since_stop_d = 4'h0;
    // Frozen cycles do not count towards the write time
    busy_len_d = write_busy ? busy_len_q + (clk_en ? 1 : 0) : 0;
  end

  always_ff @(posedge clk_sys) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    since_stop_q <= reset_n ? since_stop_d : 4'hF;
    busy_len_q <= reset_n ? busy_len_d : 0;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_out_low_only:
    assert property (sda_out == 1'h0) else $error("data value not low");
  chk_busy_line_free:
    assert property (write_busy |-> !sda_oe) else $error("pull while busy");
  chk_pull_scl_low:
    assert property ($rose(sda_oe) |-> !scl_in)
      else $error("pull began with clock high");
  chk_stable_scl_high:
    assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("data moved with clock high");
  chk_busy_after_stop:
    assert property ($rose(write_busy) |-> since_stop_q < 4'h8)
      else $error("write cycle without stop");
  chk_busy_length:
    assert property ($fell(write_busy) |-> busy_len_q == WRITE_CYCLES)
      else $error("write cycle length wrong");
  chk_wp_no_write:
    assert property ($rose(write_busy) |-> !write_protect_input)
      else $error("write while protected");
  chk_lock_sticky:
    assert property (id_page_locked |=> id_page_locked)
      else $error("lock flag dropped");

  cover property ($rose(sda_oe));
  cover property ($fell(write_busy));
  cover property ($rose(id_page_locked));
endmodule

// File: tb/tb_seesap_top.sv
`timescale 1ns/1ns
module tb_seesap_top;
  import seesap_pkg::*;
  localparam int WCYC = 200;
  logic clk_sys = 1'h0;
  logic reset_n = 1'h0;
  logic wp = 1'h0;
  logic clk_en = 1'h1;
  logic [2:0] strap = 3'h0;
  logic scl, pull, sda_out, sda_oe, busy, locked, fixed;
  wire logic sda_wire;
  logic [31:0] rs = 32'h0000_95AF;
  logic [7:0] got[$];
  int failures = 0;
  int n_compared = 0;

  // Pull-up: a released line reads high
  assign sda_wire = ~(pull | sda_oe);
  always #5 clk_sys = ~clk_sys;

  seesap_top #(.WRITE_CYCLES(WCYC)) seesap_top_inst (.clk_sys(clk_sys),
    .reset_n(reset_n), .clk_en(clk_en), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .strap_select_bit2(strap[2]),
    .strap_select_bit1(strap[1]), .strap_select_bit0(strap[0]),
    .write_protect_input(wp), .write_busy(busy), .id_page_locked(locked),
    .ecc_corrected(fixed));
  seesap_mst_model seesap_mst_model_inst (.clk_sys(clk_sys),
    .sda_wire(sda_wire), .scl(scl), .pull(pull));

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  function automatic logic [7:0] acks(input logic [3:0] t,
                                      input logic [2:0] s);
    return {7'h0, (t == TYPE_MEM || t == TYPE_ID) && s == strap};
  endfunction

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'h0 && n < WCYC + 50) begin
      @(posedge clk_sys);
      n++;
    end
    if (busy !== 1'h0) begin
      failures++;
      close_out();
    end
  endtask

  task automatic send(input logic [7:0] d, output logic a);
    logic [7:0] r;
    seesap_mst_model_inst.xfer(d, 1'h1, r, a);
    a = ~a;
  endtask

  task automatic sel(input logic [3:0] t, input logic [2:0] s,
                     input logic rw, output logic a);
    seesap_mst_model_inst.start();
    send({t, s, rw}, a);
  endtask

  task automatic wr(input logic [3:0] t, input logic [7:0] hi, lo, d,
                    input int n, input logic ok);
    logic a;
    sel(t, strap, 1'h0, a);
    chk("sel ack", {7'h0, a}, 8'h01);
    send(hi, a);
    chk("hi ack", {7'h0, a}, 8'h01);
    send(lo, a);
    chk("lo ack", {7'h0, a}, 8'h01);
    for (int i = 0; i < n; i++) begin
      send(d + 8'(i), a);
      chk("data ack", {7'h0, a}, {7'h0, ok});
    end
    seesap_mst_model_inst.stop();
    chk("busy", {7'h0, busy}, {7'h0, ok});
  endtask

  task automatic rd(input logic [3:0] t, input logic [7:0] hi, lo,
                    input int n);
    logic a;
    logic [7:0] r;
    got.delete();
    sel(t, strap, 1'h0, a);
    send(hi, a);
    send(lo, a);
    sel(t, strap, 1'h1, a);
    chk("rd ack", {7'h0, a}, 8'h01);
    for (int i = 0; i < n; i++) begin
      seesap_mst_model_inst.xfer(8'hFF, i == n - 1, r, a);
      got.push_back(r);
    end
    seesap_mst_model_inst.stop();
  endtask

  initial begin
    logic [31:0] v;
    logic [7:0] hi, lo, d;
    logic a;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'h1;
    strap <= 3'h5;
    repeat (5) @(posedge clk_sys);
    chk("lock rst", {7'h0, locked}, 8'h00);
    for (int k = 0; k < 4; k++) begin
      v = rnd();
      hi = {3'h0, v[12:8]};
      lo = {v[7:5], 5'h1F};
      d = v[23:16];
      seesap_mst_model_inst.low_len = 4;
      wr(TYPE_MEM, hi, lo, d, 3, 1'h1);
      if (k == 0) begin
        // Low clock enable must hold the write cycle where it is
        clk_en <= 1'h0;
        repeat (WCYC) @(posedge clk_sys);
        chk("freeze", {7'h0, busy}, 8'h01);
        clk_en <= 1'h1;
      end
      // Polling during the write cycle gets no answer
      sel(TYPE_MEM, strap, 1'h0, a);
      chk("poll ack", {7'h0, a}, 8'h00);
      seesap_mst_model_inst.stop();
      wait_idle();
      seesap_mst_model_inst.low_len = (k == 1) ? 20 : 4;
      rd(TYPE_MEM, hi, {lo[7:5], 5'h00}, 2);
      chk("wrap0", got[0], d + 8'h01);
      chk("wrap1", got[1], d + 8'h02);
      rd(TYPE_MEM, hi, lo, 1);
      chk("rd", got[0], d);
      chk("ecc", {7'h0, fixed}, 8'h00);
      strap <= v[26:24];
      // Let the new strap value land before the next select uses it
      @(posedge clk_sys);
    end
    wp <= 1'h1;
    wr(TYPE_MEM, hi, lo, ~d, 1, 1'h0);
    wp <= 1'h0;
    rd(TYPE_MEM, hi, lo, 1);
    chk("wp keep", got[0], d);
    seesap_mst_model_inst.low_len = 12;
    for (int k = 0; k < 24; k++) begin
      hi = (k < 16) ? 8'(k) : {4'h0, TYPE_MEM};
      lo = (k < 16) ? {5'h00, strap} : 8'(k - 16);
      sel(hi[3:0], lo[2:0], 1'h0, a);
      seesap_mst_model_inst.stop();
      chk("sel", {7'h0, a}, acks(hi[3:0], lo[2:0]));
    end
    seesap_mst_model_inst.low_len = 4;
    wr(TYPE_ID, 8'h00, 8'h07, 8'h5A, 1, 1'h1);
    wait_idle();
    rd(TYPE_ID, 8'h00, 8'h07, 1);
    chk("id rd", got[0], 8'h5A);
    wr(TYPE_ID, 8'h04, 8'h00, 8'h00, 1, 1'h1);
    wait_idle();
    wr(TYPE_ID, 8'h00, 8'h07, 8'hA5, 1, 1'h0);
    chk("locked", {7'h0, locked}, 8'h01);
    rd(TYPE_ID, 8'h00, 8'h07, 1);
    chk("id keep", got[0], 8'h5A);
    close_out();
  end
endmodule

bind seesap_top seesap_top_checker #(.WRITE_CYCLES(WRITE_CYCLES))
  seesap_top_checker_inst (.clk_sys(clk_sys), .reset_n(reset_n),
  .clk_en(clk_en),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .write_protect_input(write_protect_input), .write_busy(write_busy),
  .id_page_locked(id_page_locked));
